/* File: src/dote_engine.sv */
// output timing engine: triggers, sample clock, buffered replay, change detect
// assumes host writes and config ports are synchronous to sys_clk at 40 MHz
`timescale 1ns/1ps
`default_nettype none
`include "dote_params.svh"

module dote_engine #(
  parameter int LINES = `DOTE_LINES,
  parameter int TERMS = `DOTE_TERMS,
  parameter int DEPTH = `DOTE_FIFO_DEPTH,
  parameter int ENGINE_ID = 0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] sample_mode,
  input wire logic [1:0] timing_type,
  input wire logic hw_timed,
  input wire logic task_has_parallel,
  input wire logic task_has_serial,
  input wire logic serial_owned_by_hw,
  input wire logic parallel_high_slot,
  input wire logic [15:0] divisor,
  input wire logic [15:0] start_delay,
  input wire logic [31:0] finite_count,
  input wire logic ext_clock_sel,
  input wire logic [$clog2(TERMS)-1:0] clk_term_sel,
  input wire logic [1:0] start_src,
  input wire logic [$clog2(TERMS)-1:0] start_term_sel,
  input wire logic start_falling,
  input wire logic pause_enable,
  input wire logic pause_use_term,
  input wire logic [$clog2(TERMS)-1:0] pause_term_sel,
  input wire logic pause_internal,
  input wire logic pause_active_low,
  input wire logic filt_enable,
  input wire logic filt_tick,
  input wire logic [3:0] filt_count,
  input wire logic [TERMS-1:0] programmable_function_terminal,
  input wire logic timebase_ext,
  input wire logic analog_input_start_trigger,
  input wire logic analog_input_reference_trigger,
  input wire logic arm_cmd,
  input wire logic stop_cmd,
  input wire logic host_start_pulse,
  input wire logic sw_write,
  input wire logic [LINES-1:0] sw_data,
  input wire logic host_valid,
  input wire logic [LINES-1:0] host_data,
  input wire logic single_point_write,
  input wire logic [LINES-1:0] cd_rise_en,
  input wire logic [LINES-1:0] cd_fall_en,
  input wire logic [LINES-1:0] din,
  input wire logic cd_pop,
  output logic host_ready,
  output logic [LINES-1:0] dout,
  output logic sample_clock_out,
  output logic start_trigger_out,
  output logic edge_change_event,
  output logic [LINES-1:0] cd_sample,
  output logic cd_valid,
  output logic running,
  output logic config_error,
  output logic serial_sw_refused,
  output logic underflow_error,
  output logic single_point_late
);
  localparam int FW = 32;
  dote_fifo_if #(.W(LINES)) ofi ();
  dote_fifo_if #(.W(LINES)) cfi ();
  dote_pkg::dote_state_e state_reg;
  dote_pkg::dote_state_e state_next;

  initial
  begin
    if (ENGINE_ID < 0 || ENGINE_ID >= `DOTE_NUM_ENGINES)
      $error("engine id out of range");
    if (TERMS < 2 || LINES < 1)
      $error("unsupported width");
  end

  // edge pick used for the start trigger only
  function automatic logic edge_hit(input logic now, input logic was, input logic fall);
    edge_hit = fall ? (was && !now) : (!was && now);
  endfunction : edge_hit

  // ---------------------------------------------------------------
  // input filtering and source selection
  // ---------------------------------------------------------------
  logic clk_raw, start_raw, pause_raw;
  logic clk_f, start_f, pause_f;
  assign clk_raw = programmable_function_terminal[clk_term_sel];
  assign start_raw = programmable_function_terminal[start_term_sel];
  assign pause_raw = pause_use_term ? programmable_function_terminal[pause_term_sel]
                                    : pause_internal;

  dote_filter u_fclk (.sys_clk(sys_clk), .rst_b(rst_b), .enable(filt_enable),
    .filt_tick(filt_tick), .filt_count(filt_count), .raw_in(clk_raw), .filt_out(clk_f));
  dote_filter u_fstart (.sys_clk(sys_clk), .rst_b(rst_b), .enable(filt_enable),
    .filt_tick(filt_tick), .filt_count(filt_count), .raw_in(start_raw), .filt_out(start_f));
  dote_filter u_fpause (.sys_clk(sys_clk), .rst_b(rst_b), .enable(filt_enable),
    .filt_tick(filt_tick), .filt_count(filt_count), .raw_in(pause_raw), .filt_out(pause_f));

  logic start_lvl, start_prev_reg, clk_prev_reg, tb_prev_reg;
  logic start_edge, ext_clk_edge, tb_edge, paused;
  always_comb
  begin
    case (start_src)
      `DOTE_SRC_TERM: start_lvl = start_f;
      `DOTE_SRC_AI_START: start_lvl = analog_input_start_trigger;
      `DOTE_SRC_AI_REF: start_lvl = analog_input_reference_trigger;
      default: start_lvl = host_start_pulse;
    endcase
  end
  // host pulse and software start ignore the edge selection
  assign start_edge = (start_src == `DOTE_SRC_HOST) ? host_start_pulse
                      : edge_hit(start_lvl, start_prev_reg, start_falling);
  assign ext_clk_edge = clk_f && !clk_prev_reg;
  assign tb_edge = timebase_ext && !tb_prev_reg;
  assign paused = pause_enable && (pause_f ^ pause_active_low);

  // previous levels for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      start_prev_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      tb_prev_reg <= 1'b0;
    end
    else
    begin
      start_prev_reg <= start_lvl;
      clk_prev_reg <= clk_f;
      tb_prev_reg <= timebase_ext;
    end
  end

  // ---------------------------------------------------------------
  // task admission checks
  // ---------------------------------------------------------------
  logic bad_mix, bad_sp_timing, cfg_bad;
  assign bad_mix = hw_timed && task_has_parallel && task_has_serial;
  assign bad_sp_timing = (sample_mode == `DOTE_MODE_SINGLE_POINT)
                         && (timing_type == `DOTE_TIM_ON_DEMAND);
  assign cfg_bad = bad_mix || bad_sp_timing;

  // ---------------------------------------------------------------
  // run state machine
  // ---------------------------------------------------------------
  logic [15:0] delay_reg;
  logic [FW-1:0] done_reg;
  logic tick;
  logic buffered;
  assign buffered = sample_mode != `DOTE_MODE_SINGLE_POINT;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dote_pkg::DOTE_IDLE:
        if (arm_cmd && !cfg_bad && hw_timed && start_edge)
          state_next = (!ext_clock_sel && start_delay != 16'h0000) ? dote_pkg::DOTE_DELAY
                                                                    : dote_pkg::DOTE_RUN;
      dote_pkg::DOTE_DELAY:
        if (stop_cmd)
          state_next = dote_pkg::DOTE_IDLE;
        else if (delay_reg <= 16'h0001)
          state_next = dote_pkg::DOTE_RUN;
      dote_pkg::DOTE_RUN:
        if (stop_cmd)
          state_next = dote_pkg::DOTE_IDLE;
        else if (sample_mode == `DOTE_MODE_FINITE && tick && done_reg + 1 >= finite_count)
          state_next = dote_pkg::DOTE_DONE;
      dote_pkg::DOTE_DONE:
        state_next = dote_pkg::DOTE_IDLE;
      default:
        state_next = dote_pkg::DOTE_IDLE;
    endcase
  end

  // state and start delay
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= dote_pkg::DOTE_IDLE;
      delay_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == dote_pkg::DOTE_IDLE)
        delay_reg <= start_delay;
      else if (state_reg == dote_pkg::DOTE_DELAY)
        delay_reg <= delay_reg - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // sample clock: divider, pause gating
  // ---------------------------------------------------------------
  logic [15:0] div_reg;
  logic div_pulse, clk_event, resume_wait_reg;
  // divided timebase: internal uses every cycle, otherwise external edges
  assign div_pulse = (state_reg == dote_pkg::DOTE_RUN) && (ext_clock_sel ? 1'b0 : 1'b1)
                     && (div_reg + 16'h0001 >= divisor);
  assign clk_event = ext_clock_sel ? ext_clk_edge : div_pulse;
  // a pause in effect masks the tick of that same cycle
  assign tick = (state_reg == dote_pkg::DOTE_RUN) && clk_event
                && !paused && !resume_wait_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || state_reg != dote_pkg::DOTE_RUN)
      div_reg <= 16'h0000;
    else if (!ext_clock_sel && (timebase_ext ? tb_edge : 1'b1))
      div_reg <= (div_reg + 16'h0001 >= divisor) ? 16'h0000 : div_reg + 16'h0001;
  end

  // external clock must see a fresh edge after pause; onboard resumes at once
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      resume_wait_reg <= 1'b0;
    else if (paused && ext_clock_sel)
      resume_wait_reg <= 1'b1;
    else if (ext_clk_edge)
      resume_wait_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // output fifo and replay
  // ---------------------------------------------------------------
  logic loaded_reg;
  logic [$clog2(DEPTH):0] limit;
  // high slots reach only half the store
  assign limit = parallel_high_slot ? ($clog2(DEPTH)+1)'(DEPTH/2)
                                    : ($clog2(DEPTH)+1)'(DEPTH);
  dote_fifo #(.W(LINES), .DEPTH(DEPTH)) u_ofifo (.sys_clk(sys_clk), .rst_b(rst_b),
    .limit(limit), .f(ofi));
  assign ofi.wr_valid = host_valid && buffered
                        && !(sample_mode == `DOTE_MODE_ONBOARD && loaded_reg);
  assign ofi.wr_data = host_data;
  assign ofi.rd_pop = tick && buffered && sample_mode != `DOTE_MODE_ONBOARD;
  // onboard mode never pops or rewinds, so each tick replays the oldest kept word
  assign ofi.rewind = 1'b0;
  assign ofi.flush = state_reg == dote_pkg::DOTE_DONE || stop_cmd;

  // onboard load locks once running
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || state_reg == dote_pkg::DOTE_IDLE)
      loaded_reg <= 1'b0;
    else if (state_reg == dote_pkg::DOTE_RUN && sample_mode == `DOTE_MODE_ONBOARD)
      loaded_reg <= 1'b1;
  end

  // ---------------------------------------------------------------
  // output update, count, error flags
  // ---------------------------------------------------------------
  logic [LINES-1:0] dout_reg;
  logic sp_pending_reg;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      dout_reg <= '0;
    else if (tick && buffered && ofi.rd_valid)
      dout_reg <= ofi.rd_data;
    else if (tick && !buffered)
      dout_reg <= host_data;
    else if (sw_write && !hw_timed && !(task_has_serial && serial_owned_by_hw))
      dout_reg <= sw_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || state_reg == dote_pkg::DOTE_IDLE)
      done_reg <= '0;
    else if (tick)
      done_reg <= done_reg + 1'b1;
  end

  // sticky flags; a fresh event wins over arm clearing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      underflow_error <= 1'b0;
      single_point_late <= 1'b0;
      config_error <= 1'b0;
      serial_sw_refused <= 1'b0;
      sp_pending_reg <= 1'b0;
    end
    else
    begin
      if (tick && !ofi.rd_valid && sample_mode == `DOTE_MODE_NONREGEN)
        underflow_error <= 1'b1;
      else if (arm_cmd)
        underflow_error <= 1'b0;
      if (tick && !buffered && !sp_pending_reg)
        single_point_late <= 1'b1;
      else if (arm_cmd)
        single_point_late <= 1'b0;
      if (arm_cmd && cfg_bad)
        config_error <= 1'b1;
      else if (arm_cmd)
        config_error <= 1'b0;
      if (sw_write && task_has_serial && serial_owned_by_hw)
        serial_sw_refused <= 1'b1;
      else if (arm_cmd)
        serial_sw_refused <= 1'b0;
      if (single_point_write)
        sp_pending_reg <= 1'b1;
      else if (tick)
        sp_pending_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // change detection: sample all lines into a fifo
  // ---------------------------------------------------------------
  logic [LINES-1:0] din_prev_reg;
  logic cd_hit;
  assign cd_hit = |((din & ~din_prev_reg & cd_rise_en) | (~din & din_prev_reg & cd_fall_en));
  dote_fifo #(.W(LINES), .DEPTH(DEPTH)) u_cfifo (.sys_clk(sys_clk), .rst_b(rst_b),
    .limit(($clog2(DEPTH)+1)'(DEPTH)), .f(cfi));
  assign cfi.wr_valid = cd_hit;
  assign cfi.wr_data = din;
  assign cfi.rd_pop = cd_pop;
  assign cfi.rewind = 1'b0;
  assign cfi.flush = 1'b0;

  // routed outputs, all registered
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      din_prev_reg <= '0;
      sample_clock_out <= 1'b0;
      start_trigger_out <= 1'b0;
      edge_change_event <= 1'b0;
      cd_sample <= '0;
      cd_valid <= 1'b0;
      running <= 1'b0;
      host_ready <= 1'b0;
    end
    else
    begin
      din_prev_reg <= din;
      sample_clock_out <= tick;
      start_trigger_out <= state_reg == dote_pkg::DOTE_IDLE
                           && state_next != dote_pkg::DOTE_IDLE;
      edge_change_event <= cd_hit;
      cd_sample <= cfi.rd_data;
      cd_valid <= cfi.rd_valid;
      running <= state_next == dote_pkg::DOTE_RUN || state_next == dote_pkg::DOTE_DELAY;
      host_ready <= ofi.wr_ready && !(sample_mode == `DOTE_MODE_ONBOARD && loaded_reg);
    end
  end
  assign dout = dout_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_armed_start;
    state_reg == dote_pkg::DOTE_IDLE && arm_cmd && !cfg_bad && hw_timed && start_edge;
  endsequence
  property p_start_pulse;
    @(posedge sys_clk) disable iff (!rst_b) s_armed_start |=> start_trigger_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("no start pulse");
  property p_refuse_mix;
    @(posedge sys_clk) disable iff (!rst_b) (arm_cmd && bad_mix) |=> config_error;
  endproperty
  a_refuse_mix: assert property (p_refuse_mix) else $error("mix not refused");
  property p_underflow;
    @(posedge sys_clk) disable iff (!rst_b)
    (tick && !ofi.rd_valid && sample_mode == `DOTE_MODE_NONREGEN) |=> underflow_error;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow missed");
  property p_pause_blocks;
    @(posedge sys_clk) disable iff (!rst_b) paused |=> !sample_clock_out;
  endproperty
  a_pause_blocks: assert property (p_pause_blocks) else $error("sample while paused");
  property p_finite_stop;
    @(posedge sys_clk) disable iff (!rst_b)
    state_reg == dote_pkg::DOTE_DONE |=> state_reg == dote_pkg::DOTE_IDLE;
  endproperty
  a_finite_stop: assert property (p_finite_stop) else $error("finite did not stop");
  property p_cd_sample;
    @(posedge sys_clk) disable iff (!rst_b) cd_hit |=> edge_change_event;
  endproperty
  a_cd_sample: assert property (p_cd_sample) else $error("change not flagged");
  property p_sp_reject;
    @(posedge sys_clk) disable iff (!rst_b) (arm_cmd && bad_sp_timing) |=> !running;
  endproperty
  a_sp_reject: assert property (p_sp_reject) else $error("bad timing ran");
  property p_onboard_lock;
    @(posedge sys_clk) disable iff (!rst_b)
    (loaded_reg && sample_mode == `DOTE_MODE_ONBOARD) |-> !ofi.wr_valid;
  endproperty
  a_onboard_lock: assert property (p_onboard_lock) else $error("onboard write");
endmodule : dote_engine
`default_nettype wire

/* File: src/dote_params.svh */
// timing engine constants: reset values, field codes and widths
// assumes inclusion by bare name from the design files
`ifndef DOTE_PARAMS_SVH
`define DOTE_PARAMS_SVH

`define DOTE_NUM_ENGINES 8
`define DOTE_LINES 8
`define DOTE_TERMS 4
`define DOTE_FIFO_DEPTH 64
`define DOTE_FIFO_DEPTH_HIGH_SLOT 32
`define DOTE_DIV_RESET 16'h0001
`define DOTE_FILT_RESET 4'h3

// start trigger source codes
`define DOTE_SRC_HOST 2'h0
`define DOTE_SRC_TERM 2'h1
`define DOTE_SRC_AI_START 2'h2
`define DOTE_SRC_AI_REF 2'h3

// timing type codes
`define DOTE_TIM_SAMPLE_CLOCK 2'h0
`define DOTE_TIM_CHANGE_DETECT 2'h1
`define DOTE_TIM_ON_DEMAND 2'h2

// sample mode codes
`define DOTE_MODE_FINITE 3'h0
`define DOTE_MODE_REGEN 3'h1
`define DOTE_MODE_ONBOARD 3'h2
`define DOTE_MODE_NONREGEN 3'h3
`define DOTE_MODE_SINGLE_POINT 3'h4

`endif

/* File: src/dote_pkg.sv */
// types used by the timing engine run state machine
// assumes dote_params.svh holds the numeric codes
package dote_pkg;
  typedef enum logic [1:0] {
    DOTE_IDLE = 2'b00,
    DOTE_DELAY = 2'b01,
    DOTE_RUN = 2'b10,
    DOTE_DONE = 2'b11
  } dote_state_e;
endpackage : dote_pkg

/* File: src/dote_fifo_if.sv */
// interface between the engine core and its sample fifo
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface dote_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_pop;
  logic [W-1:0] rd_data;
  logic rewind;
  logic flush;
  modport owner (input wr_valid, wr_data, rd_pop, rewind, flush,
                 output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_pop, rewind, flush,
                input wr_ready, rd_valid, rd_data);
endinterface : dote_fifo_if
`default_nettype wire

/* File: src/dote_filter.sv */
// consecutive-sample debouncer for one timing input
// assumes filter clock enable is a one-cycle pulse of sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "dote_params.svh"
module dote_filter (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic filt_tick,
  input wire logic [3:0] filt_count,
  input wire logic raw_in,
  output logic filt_out
);
  logic [3:0] run_reg;
  logic out_reg;

  // new level passes only after N consecutive ticks agree
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      run_reg <= 4'h0;
      out_reg <= 1'b0;
    end
    else if (!enable)
    begin
      run_reg <= 4'h0;
      out_reg <= raw_in;
    end
    else if (filt_tick)
    begin
      if (raw_in == out_reg)
        run_reg <= 4'h0;
      else if (run_reg + 4'h1 >= filt_count)
      begin
        out_reg <= raw_in;
        run_reg <= 4'h0;
      end
      else
        run_reg <= run_reg + 4'h1;
    end
  end
  assign filt_out = out_reg;

  property p_filter_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (enable && $past(enable) && $past(rst_b) && !$past(filt_tick)) |-> $stable(out_reg);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter moved without tick");
endmodule : dote_filter
`default_nettype wire

/* File: src/dote_fifo.sv */
// sample fifo with rewind; the engine ties rewind low, so onboard replay does not use it
// assumes writer and reader share sys_clk
`timescale 1ns/1ps
`default_nettype none
module dote_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [$clog2(DEPTH):0] limit,
  dote_fifo_if.owner f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic [AW:0] level;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("fifo depth must be a power of two");
  end

  assign level = wr_reg - rd_reg;
  assign f.wr_ready = level < limit;
  assign f.rd_valid = level != '0;
  assign f.rd_data = mem[rd_reg[AW-1:0]];

  // pointers; rewind replays from the oldest kept word
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || f.flush)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (f.wr_valid && f.wr_ready)
        wr_reg <= wr_reg + 1'b1;
      if (f.rewind)
        rd_reg <= '0;
      else if (f.rd_pop && f.rd_valid)
        rd_reg <= rd_reg + 1'b1;
    end
  end

  // storage
  always_ff @(posedge sys_clk)
  begin
    if (f.wr_valid && f.wr_ready)
      mem[wr_reg[AW-1:0]] <= f.wr_data;
  end
endmodule : dote_fifo
`default_nettype wire

/* File: tb/dote_module_model.sv */
// far side: output module latching all lines on each sample clock
// assumes sample_clock_out and dout are registered on sys_clk
`timescale 1ns/1ps
`default_nettype none
module dote_module_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sample_clock_out,
  input wire logic [7:0] dout,
  output var int updates,
  output logic [7:0] latched
);
  // the whole word is taken at once, never line by line
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      updates <= 0;
      latched <= 8'h00;
    end
    else if (sample_clock_out)
    begin
      updates <= updates + 1;
      latched <= dout;
    end
  end
endmodule : dote_module_model
`default_nettype wire

/* File: tb/digital_output_timing_engine_bench.sv */
// bench: finite runs on every start source, refusals, underflow
// assumes dote_engine at default widths and the module model
`timescale 1ns/1ps
`default_nettype none
`include "dote_params.svh"
module digital_output_timing_engine_bench;
  logic sys_clk, rst_b, hw_timed, task_has_parallel, task_has_serial, serial_owned_by_hw;
  logic parallel_high_slot, ext_clock_sel, start_falling, pause_enable, pause_use_term;
  logic pause_internal, pause_active_low, filt_enable, filt_tick, timebase_ext, arm_cmd;
  logic analog_input_start_trigger, analog_input_reference_trigger, stop_cmd, cd_pop;
  logic host_start_pulse, sw_write, host_valid, single_point_write, host_ready, cd_valid;
  logic sample_clock_out, start_trigger_out, edge_change_event, running, config_error;
  logic serial_sw_refused, underflow_error, single_point_late;
  logic [2:0] sample_mode;
  logic [1:0] timing_type, start_src, clk_term_sel, start_term_sel, pause_term_sel;
  logic [15:0] divisor, start_delay;
  logic [31:0] finite_count, seed, miscompares, comparisons, cycles;
  logic [3:0] filt_count, programmable_function_terminal;
  logic [7:0] sw_data, host_data, cd_rise_en, cd_fall_en, din, dout, cd_sample, latched;
  int updates, last_t, t, n, got, base, last_w;
  int model_q[$];
  dote_engine dote_engine_i (.*);
  dote_module_model dote_module_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .sample_clock_out(sample_clock_out), .dout(dout), .updates(updates), .latched(latched));
  // ----------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // a stuck handshake must not hold the run forever
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 32'd20000)
    begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      miscompares = miscompares + 1;
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // arm together with the chosen start edge, then release both
  task automatic arm(input logic [1:0] src);
    @(posedge sys_clk);
    start_src <= src;
    // the terminal crosses a filter register, so it rises one edge early
    if (src == `DOTE_SRC_TERM)
      programmable_function_terminal <= 4'h1;
    @(posedge sys_clk);
    arm_cmd <= 1'b1;
    case (src)
      `DOTE_SRC_HOST: host_start_pulse <= 1'b1;
      `DOTE_SRC_TERM: programmable_function_terminal <= 4'h1;
      `DOTE_SRC_AI_START: analog_input_start_trigger <= 1'b1;
      default: analog_input_reference_trigger <= 1'b1;
    endcase
    @(posedge sys_clk);
    {arm_cmd, host_start_pulse, analog_input_start_trigger} <= 3'h0;
    {analog_input_reference_trigger, programmable_function_terminal} <= 5'h00;
    @(negedge sys_clk);
  endtask : arm
  // fill the fifo, run a finite burst, compare every sample with the queue
  task automatic run_finite(input logic [1:0] src);
    {sample_mode, timing_type} = {`DOTE_MODE_FINITE, `DOTE_TIM_SAMPLE_CLOCK};
    divisor = 16'(src) + 16'h0001;
    n = 3 + int'(seed[1:0]);
    finite_count = 32'(n);
    for (int i = 0; i < n; i++)
    begin
      seed = xs(seed);
      model_q.push_back(int'(seed[7:0]));
      // the fifo takes a word at every edge that sees valid, so one word per edge
      do @(negedge sys_clk); while (host_ready !== 1'b1);
      @(posedge sys_clk);
      host_valid <= 1'b1;
      host_data <= seed[7:0];
    end
    @(posedge sys_clk);
    host_valid <= 1'b0;
    base = updates;
    arm(src);
    check("start pulse", start_trigger_out, 1);
    check("running", running, 1);
    got = 0;
    last_t = -1;
    for (t = 0; t < 200 && running === 1'b1; t++)
    begin
      @(negedge sys_clk);
      if (sample_clock_out === 1'b1)
      begin
        last_w = model_q.pop_front();
        check("dout", dout, last_w);
        if (last_t >= 0)
          check("spacing", t - last_t, divisor);
        last_t = t;
        got++;
      end
    end
    check("samples", got, n);
    // the module takes the last word one edge after its pulse
    @(negedge sys_clk);
    check("module updates", updates - base, n);
    check("module word", latched, last_w);
    $display("finite run from source %0d done", src);
  endtask : run_finite
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst_b, task_has_serial, serial_owned_by_hw, parallel_high_slot, ext_clock_sel} = 5'h0;
    {start_falling, pause_enable, pause_use_term, pause_internal, pause_active_low} = 5'h0;
    {filt_enable, filt_tick, timebase_ext, arm_cmd, stop_cmd, cd_pop, sw_write} = 7'h00;
    {analog_input_start_trigger, analog_input_reference_trigger, host_valid} = 3'h0;
    {host_start_pulse, single_point_write, programmable_function_terminal} = 6'h00;
    {hw_timed, task_has_parallel, start_delay, filt_count} = {2'h3, 16'h0000, 4'h3};
    {clk_term_sel, start_term_sel, pause_term_sel, start_src} = 8'h00;
    {sw_data, host_data, cd_rise_en, cd_fall_en, din} = 40'h0;
    {sample_mode, timing_type, divisor, finite_count} = 53'h0;
    {seed, miscompares, comparisons, cycles} = {32'hc31b, 96'h0};
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    check("idle outputs", {running, dout, underflow_error, config_error}, 0);
    for (int s = 0; s < 4; s++)
      run_finite(2'(s));
    // mixed module kinds must be refused
    task_has_serial = 1'b1;
    arm(`DOTE_SRC_HOST);
    check("mix refused", {config_error, running}, 2'b10);
    task_has_serial = 1'b0;
    {sample_mode, timing_type} = {`DOTE_MODE_SINGLE_POINT, `DOTE_TIM_ON_DEMAND};
    arm(`DOTE_SRC_HOST);
    check("single point refused", {config_error, running}, 2'b10);
    // empty fifo in non-regeneration must flag underflow
    {sample_mode, timing_type, divisor} = {`DOTE_MODE_NONREGEN, 2'h0, 16'h0002};
    arm(`DOTE_SRC_HOST);
    repeat (6) @(negedge sys_clk);
    check("underflow", underflow_error, 1);
    check("no stale error", config_error, 0);
    $display("refusal and underflow tests done");
    // one host command per software update, then a serial module held by hardware
    @(posedge sys_clk);
    {stop_cmd, hw_timed, sw_write, sw_data} <= {3'h5, seed[7:0]};
    @(posedge sys_clk);
    {stop_cmd, sw_write, task_has_serial, serial_owned_by_hw} <= 4'h3;
    @(negedge sys_clk);
    check("software write", dout, seed[7:0]);
    @(posedge sys_clk);
    {sw_write, sw_data} <= {1'b1, ~seed[7:0]};
    @(posedge sys_clk);
    sw_write <= 1'b0;
    @(negedge sys_clk);
    check("serial refused", {serial_sw_refused, dout}, {1'b1, seed[7:0]});
    // a watched rising edge stores the whole word; the filter must hold without ticks
    @(posedge sys_clk);
    {cd_rise_en, din} <= {8'h01, seed[15:8] | 8'h01};
    {filt_enable, programmable_function_terminal} <= 5'h1f;
    repeat (2) @(negedge sys_clk);
    check("change event", edge_change_event, 1);
    @(negedge sys_clk);
    check("change word", {cd_valid, cd_sample}, {1'b1, seed[15:8] | 8'h01});
    $display("software and change detection tests done");
    report_and_stop();
  end
endmodule : digital_output_timing_engine_bench
`default_nettype wire
